//--- include/uodc_pkg.sv
// constants, types and register map of the descriptor configuration bank
// Overview of operation
// - mode bit 1 set: pin 9 drives the receive toggle, else general purpose
// - mode bit 0 set: pin 8 drives the transmit toggle, else general purpose
// - low direction byte: bit n one makes pin n output, zero input
// - high direction bits 1:0 set direction of pins 9 and 8
// - cleared mask bit: input change sends an interrupt packet; set suppresses
// - latency rate threshold is 24 bits, lowest address holds least byte
// - vendor code: lower address gives bits 7:0, next gives 15:8
// - product code: lower address gives bits 7:0, next gives 15:8
// - max power byte reported in 2 mA steps; host keeps it within range
// - wake valid set: bmAttributes D5 follows the wake enable bit
// - wake valid clear: wake enable bit never reaches D5
// - power field 00 reports bus powered, 01 or 10 self powered, 11 forbidden; the code reports 11 as bus powered
// - stored direction used only when the direction override bit is set
// - stored threshold used only when the threshold override bit is set
// - descriptor values taken from storage only when their programmed flag is set
package uodc_pkg;
   localparam int NPIN  = 10;
   localparam int NSLOT = 16;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_OVERRIDE = 8'h07;
   localparam logic [7:0] IDX_MODE_HI  = 8'h0a;
   localparam logic [7:0] IDX_DIR_LO   = 8'h0b;
   localparam logic [7:0] IDX_DIR_HI   = 8'h0c;
   localparam logic [7:0] IDX_MASK_LO  = 8'h0d;
   localparam logic [7:0] IDX_MASK_HI  = 8'h0e;
   localparam logic [7:0] IDX_THR0     = 8'h0f;
   localparam logic [7:0] IDX_THR1     = 8'h10;
   localparam logic [7:0] IDX_THR2     = 8'h11;
   localparam logic [7:0] IDX_VEND_LO  = 8'h12;
   localparam logic [7:0] IDX_VEND_HI  = 8'h13;
   localparam logic [7:0] IDX_PROD_LO  = 8'h14;
   localparam logic [7:0] IDX_PROD_HI  = 8'h15;
   localparam logic [7:0] IDX_MAXPWR   = 8'h16;
   localparam logic [7:0] IDX_ATTR     = 8'h17;
   localparam logic [7:0] IDX_PROG     = 8'h1e;
   localparam logic [7:0] IDX_CTRL     = 8'h20;
   localparam logic [7:0] IDX_STATUS   = 8'h21;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h22;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h23;
   localparam logic [7:0] IDX_GPIO_OUT = 8'h24;
   localparam logic [7:0] IDX_GPIO_IN  = 8'h25;
   // storage slots, in the same order as the table below
   localparam logic [3:0] SLOT_OVR = 4'h0;
   localparam logic [3:0] SLOT_MODE = 4'h1;
   localparam logic [3:0] SLOT_DIR_LO = 4'h2;
   localparam logic [3:0] SLOT_DIR_HI = 4'h3;
   localparam logic [3:0] SLOT_MASK_LO = 4'h4;
   localparam logic [3:0] SLOT_MASK_HI = 4'h5;
   localparam logic [3:0] SLOT_THR0 = 4'h6;
   localparam logic [3:0] SLOT_THR1 = 4'h7;
   localparam logic [3:0] SLOT_THR2 = 4'h8;
   localparam logic [3:0] SLOT_VEND_LO = 4'h9;
   localparam logic [3:0] SLOT_VEND_HI = 4'ha;
   localparam logic [3:0] SLOT_PROD_LO = 4'hb;
   localparam logic [3:0] SLOT_PROD_HI = 4'hc;
   localparam logic [3:0] SLOT_MAXPWR = 4'hd;
   localparam logic [3:0] SLOT_ATTR = 4'he;
   localparam logic [3:0] SLOT_PROG = 4'hf;
   localparam logic [3:0] SLOT_LAST = 4'hf;
   localparam logic [NSLOT-1:0][7:0] IDX_OF_SLOT = {
      IDX_PROG, IDX_ATTR, IDX_MAXPWR, IDX_PROD_HI, IDX_PROD_LO, IDX_VEND_HI, IDX_VEND_LO,
      IDX_THR2, IDX_THR1, IDX_THR0, IDX_MASK_HI, IDX_MASK_LO, IDX_DIR_HI, IDX_DIR_LO,
      IDX_MODE_HI, IDX_OVERRIDE};
   // storage reset values, only the mode byte is non-zero
   localparam logic [7:0] MODE_HI_RST = 8'h03;
   localparam logic [NSLOT-1:0][7:0] SLOT_RST = {{14{8'h00}}, MODE_HI_RST, 8'h00};
   // field positions
   localparam int OVR_MODE_BIT   = 1;
   localparam int OVR_DIR_BIT    = 2;
   localparam int OVR_MASK_BIT   = 3;
   localparam int OVR_THR_BIT    = 4;
   localparam int PROG_VEND_BIT  = 0;
   localparam int PROG_PROD_BIT  = 1;
   localparam int PROG_PWR_BIT   = 2;
   localparam int PROG_ATTR_BIT  = 3;
   localparam int MODE_TX_BIT    = 0;
   localparam int MODE_RX_BIT    = 1;
   localparam int ATTR_WAKE_VALID = 2;
   localparam int ATTR_WAKE_EN   = 3;
   localparam int BM_WAKE_BIT    = 5;
   localparam int BM_SELF_BIT    = 6;
   localparam int TX_PIN         = 8;
   localparam int RX_PIN         = 9;
   localparam logic [1:0] PWR_SELF_A = 2'b01;
   localparam logic [1:0] PWR_SELF_B = 2'b10;
   localparam logic [7:0] BM_BASE    = 8'h80;
   // built-in driver mode defaults
   localparam logic [7:0]  DEF_MODE    = 8'h03;
   localparam logic [9:0]  DEF_DIR     = 10'h000;
   localparam logic [9:0]  DEF_MASK    = 10'h000;
   localparam logic [23:0] DEF_THR     = 24'h000000;
   localparam logic [15:0] DEF_VENDOR  = 16'h1234; // arbitrary value
   localparam logic [15:0] DEF_PRODUCT = 16'h5678; // arbitrary value
   localparam logic [7:0]  DEF_MAXPWR  = 8'h32;
   localparam logic [7:0]  DEF_ATTR    = 8'h00;
   // control, status and interrupt fields
   localparam int CTRL_RELOAD_BIT = 0;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_READY_BIT  = 1;
   localparam int IRQ_W           = 2;
   localparam int IRQ_LOAD_BIT    = 0;
   localparam int IRQ_PIN_BIT     = 1;
   typedef struct packed {
      logic [15:0] vendor;
      logic [15:0] product;
      logic [7:0]  max_power;
      logic [7:0]  attributes;
   } uodc_desc_t;
   typedef struct packed {
      logic [9:0] dir;
      logic [9:0] mask;
      logic       rx_tog_sel;
      logic       tx_tog_sel;
   } uodc_pincfg_t;
endpackage

//--- hdl/uodc_store.sv
// byte storage of the configuration bank, one flip-flop byte per slot
module uodc_store (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // write port
   input  wire logic       wr_en,
   input  wire logic [3:0] wr_slot,
   input  wire logic [7:0] wr_data,
   // read port
   input  wire logic [3:0] rd_slot,
   output logic      [7:0] rd_data
);
   logic [uodc_pkg::NSLOT-1:0][7:0] mem_q;

   for (genvar s = 0; s < uodc_pkg::NSLOT; s++) begin : g_slot
      always_ff @(posedge clk) begin
         if (rst) begin
            mem_q[s] <= uodc_pkg::SLOT_RST[s];
         end else if (wr_en && wr_slot == 4'(s)) begin
            mem_q[s] <= wr_data;
         end
      end
   end

   assign rd_data = mem_q[rd_slot];
endmodule

//--- hdl/uodc_top.sv
// configuration bank with apb access, loader, pin control and descriptor values
module uodc_top (
   // clock and reset
   input  wire logic                  MCLK,
   input  wire logic                  RST,
   // apb slave
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [11:0]           PADDR,
   input  wire logic [31:0]           PWDATA,
   output logic      [31:0]           PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   // general purpose pins
   input  wire logic [9:0]            GPIO_I,
   output logic      [9:0]            GPIO_O,
   output logic      [9:0]            GPIO_OE_N,
   // uart activity
   input  wire logic                  TX_ACTIVITY,
   input  wire logic                  RX_ACTIVITY,
   // interrupt packet request
   output logic                       PIN_CHANGE_PKT,
   output logic      [9:0]            PIN_CHANGE_LEVELS,
   // descriptor values for enumeration
   output uodc_pkg::uodc_desc_t       DESC,
   output logic                       DESC_READY,
   output logic      [23:0]           LATENCY_RATE_THRESHOLD,
   // interrupt
   output logic                       IRQ
);
   typedef enum logic [1:0] {LD_IDLE, LD_RUN, LD_APPLY} uodc_ld_t;

   uodc_ld_t                        ld_state_q;
   logic [3:0]                      ld_slot_q;
   logic [uodc_pkg::NSLOT-1:0][7:0] img_q;
   logic [7:0]                      store_rd;
   logic [3:0]                      rd_slot;
   logic                            busy;
   logic [31:0]                     prdata_q;
   logic                            pready_q;
   logic                            pslverr_q;
   logic [31:0]                     rd_word;
   logic                            rd_err;
   logic [4:0]                      hit;
   logic                            wr_fire;
   logic                            bank_wr;
   logic                            reload_req;
   uodc_pkg::uodc_desc_t            desc_q;
   uodc_pkg::uodc_desc_t            desc_d;
   uodc_pkg::uodc_pincfg_t          pincfg_q;
   uodc_pkg::uodc_pincfg_t          pincfg_d;
   logic [23:0]                     thr_q;
   logic [23:0]                     thr_d;
   logic                            ready_q;
   logic [9:0]                      gpio_in_q;
   logic [9:0]                      gpio_out_q;
   logic [9:0]                      gpio_sel;
   logic [9:0]                      chg;
   logic [9:0]                      gpio_o_q;
   logic [9:0]                      gpio_oe_n_q;
   logic                            tx_tog_q;
   logic                            rx_tog_q;
   logic                            pkt_q;
   logic [9:0]                      levels_q;
   logic [uodc_pkg::IRQ_W-1:0]      irq_stat_q;
   logic [uodc_pkg::IRQ_W-1:0]      irq_stat_d;
   logic [uodc_pkg::IRQ_W-1:0]      irq_mask_q;
   logic [uodc_pkg::IRQ_W-1:0]      irq_set;
   logic                            irq_q;

   // slot lookup from register index, msb flags a hit
   function automatic logic [4:0] slot_of(input logic [7:0] idx);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < uodc_pkg::NSLOT; i++) begin
         if (idx == uodc_pkg::IDX_OF_SLOT[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // power field and wake bits into bmAttributes
   function automatic logic [7:0] build_bm(input logic [7:0] attr);
      logic [7:0] bm;
      bm = uodc_pkg::BM_BASE;
      bm[uodc_pkg::BM_SELF_BIT] = (attr[1:0] == uodc_pkg::PWR_SELF_A) ||
                                  (attr[1:0] == uodc_pkg::PWR_SELF_B);
      bm[uodc_pkg::BM_WAKE_BIT] = attr[uodc_pkg::ATTR_WAKE_VALID] &
                                  attr[uodc_pkg::ATTR_WAKE_EN];
      return bm;
   endfunction

   assign busy    = (ld_state_q != LD_IDLE);
   assign hit     = slot_of(PADDR[9:2]);
   assign rd_slot = busy ? ld_slot_q : hit[3:0];
   assign wr_fire = PSEL & PENABLE & pready_q & PWRITE & ~pslverr_q;
   assign bank_wr = wr_fire & hit[4];
   assign reload_req = wr_fire && PADDR[9:2] == uodc_pkg::IDX_CTRL &&
                       PWDATA[uodc_pkg::CTRL_RELOAD_BIT];

   uodc_store u_store (
      .clk     (MCLK),
      .rst     (RST),
      .wr_en   (bank_wr),
      .wr_slot (hit[3:0]),
      .wr_data (PWDATA[7:0]),
      .rd_slot (rd_slot),
      .rd_data (store_rd)
   );

   // read data and unmapped decode
   always_comb begin
      rd_word = 32'h00000000;
      rd_err  = 1'b0;
      if (PADDR[11:10] != 2'b00 || PADDR[1:0] != 2'b00) begin
         rd_err = 1'b1;
      end else if (hit[4]) begin
         rd_word = {24'h000000, store_rd};
      end else begin
         case (PADDR[9:2])
            uodc_pkg::IDX_CTRL:     rd_word = 32'h00000000;
            uodc_pkg::IDX_STATUS:   rd_word = {30'h00000000, ready_q, busy};
            uodc_pkg::IDX_IRQ_STAT: rd_word = {30'h00000000, irq_stat_q};
            uodc_pkg::IDX_IRQ_MASK: rd_word = {30'h00000000, irq_mask_q};
            uodc_pkg::IDX_GPIO_OUT: rd_word = {22'h000000, gpio_out_q};
            uodc_pkg::IDX_GPIO_IN:  rd_word = {22'h000000, gpio_in_q};
            default:                rd_err  = 1'b1;
         endcase
      end
   end

   // apb handshake, answers only while the loader is idle
   always_ff @(posedge MCLK) begin
      if (RST) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else if (PSEL && PENABLE && pready_q) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (PSEL && !pready_q && !busy) begin
         pready_q  <= 1'b1;
         pslverr_q <= rd_err;
         prdata_q  <= PWRITE ? 32'h00000000 : rd_word;
      end
   end

   // loader walks every slot into the image
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ld_state_q <= LD_RUN;
         ld_slot_q  <= 4'h0;
      end else begin
         case (ld_state_q)
            LD_IDLE: begin
               if (reload_req) begin
                  ld_state_q <= LD_RUN;
                  ld_slot_q  <= 4'h0;
               end
            end
            LD_RUN: begin
               ld_slot_q <= ld_slot_q + 4'h1;
               if (ld_slot_q == uodc_pkg::SLOT_LAST) begin
                  ld_state_q <= LD_APPLY;
               end
            end
            LD_APPLY: ld_state_q <= LD_IDLE;
            default:  ld_state_q <= LD_IDLE;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         img_q <= '0;
      end else if (ld_state_q == LD_RUN) begin
         img_q[ld_slot_q] <= store_rd;
      end
   end

   // working values from the loaded image
   always_comb begin
      logic [7:0] ovr;
      logic [7:0] prog;
      logic [7:0] mode;
      logic [7:0] attr;
      ovr  = img_q[uodc_pkg::SLOT_OVR];
      prog = img_q[uodc_pkg::SLOT_PROG];
      mode = ovr[uodc_pkg::OVR_MODE_BIT] ? img_q[uodc_pkg::SLOT_MODE] : uodc_pkg::DEF_MODE;
      attr = prog[uodc_pkg::PROG_ATTR_BIT] ? img_q[uodc_pkg::SLOT_ATTR] : uodc_pkg::DEF_ATTR;
      pincfg_d.rx_tog_sel = mode[uodc_pkg::MODE_RX_BIT];
      pincfg_d.tx_tog_sel = mode[uodc_pkg::MODE_TX_BIT];
      pincfg_d.dir = ovr[uodc_pkg::OVR_DIR_BIT] ?
                     {img_q[uodc_pkg::SLOT_DIR_HI][1:0], img_q[uodc_pkg::SLOT_DIR_LO]} :
                     uodc_pkg::DEF_DIR;
      pincfg_d.mask = ovr[uodc_pkg::OVR_MASK_BIT] ?
                      {img_q[uodc_pkg::SLOT_MASK_HI][1:0], img_q[uodc_pkg::SLOT_MASK_LO]} :
                      uodc_pkg::DEF_MASK;
      thr_d = ovr[uodc_pkg::OVR_THR_BIT] ?
              {img_q[uodc_pkg::SLOT_THR2], img_q[uodc_pkg::SLOT_THR1],
               img_q[uodc_pkg::SLOT_THR0]} : uodc_pkg::DEF_THR;
      desc_d.vendor = prog[uodc_pkg::PROG_VEND_BIT] ?
                      {img_q[uodc_pkg::SLOT_VEND_HI], img_q[uodc_pkg::SLOT_VEND_LO]} :
                      uodc_pkg::DEF_VENDOR;
      desc_d.product = prog[uodc_pkg::PROG_PROD_BIT] ?
                       {img_q[uodc_pkg::SLOT_PROD_HI], img_q[uodc_pkg::SLOT_PROD_LO]} :
                       uodc_pkg::DEF_PRODUCT;
      desc_d.max_power = prog[uodc_pkg::PROG_PWR_BIT] ?
                         img_q[uodc_pkg::SLOT_MAXPWR] : uodc_pkg::DEF_MAXPWR;
      desc_d.attributes = build_bm(attr);
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         desc_q   <= '0;
         thr_q    <= 24'h000000;
         pincfg_q <= '{dir: 10'h000, mask: 10'h3ff, rx_tog_sel: 1'b0, tx_tog_sel: 1'b0};
         ready_q  <= 1'b0;
      end else if (ld_state_q == LD_APPLY) begin
         desc_q   <= desc_d;
         thr_q    <= thr_d;
         pincfg_q <= pincfg_d;
         ready_q  <= 1'b1;
      end else if (reload_req) begin
         ready_q  <= 1'b0;
      end
   end

   // activity toggles
   always_ff @(posedge MCLK) begin
      if (RST) begin
         tx_tog_q <= 1'b0;
         rx_tog_q <= 1'b0;
      end else begin
         tx_tog_q <= tx_tog_q ^ TX_ACTIVITY;
         rx_tog_q <= rx_tog_q ^ RX_ACTIVITY;
      end
   end

   // pin drivers and change detection
   assign gpio_sel = {~pincfg_q.rx_tog_sel, ~pincfg_q.tx_tog_sel, 8'hff};
   assign chg = (GPIO_I ^ gpio_in_q) & ~pincfg_q.dir & ~pincfg_q.mask & gpio_sel &
                {10{ready_q}};

   for (genvar p = 0; p < uodc_pkg::NPIN; p++) begin : g_pin
      always_ff @(posedge MCLK) begin
         if (RST) begin
            gpio_o_q[p]    <= 1'b0;
            gpio_oe_n_q[p] <= 1'b1;
         end else if (!gpio_sel[p]) begin
            gpio_o_q[p]    <= (p == uodc_pkg::RX_PIN) ? rx_tog_q : tx_tog_q;
            gpio_oe_n_q[p] <= 1'b0;
         end else begin
            gpio_o_q[p]    <= gpio_out_q[p];
            gpio_oe_n_q[p] <= ~pincfg_q.dir[p];
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         gpio_in_q <= 10'h000;
         pkt_q     <= 1'b0;
         levels_q  <= 10'h000;
      end else begin
         gpio_in_q <= GPIO_I;
         pkt_q     <= |chg;
         if (|chg) begin
            levels_q <= GPIO_I;
         end
      end
   end

   // software registers
   always_ff @(posedge MCLK) begin
      if (RST) begin
         gpio_out_q <= 10'h000;
         irq_mask_q <= '0;
      end else if (wr_fire) begin
         if (PADDR[9:2] == uodc_pkg::IDX_GPIO_OUT) begin
            gpio_out_q <= PWDATA[9:0];
         end
         if (PADDR[9:2] == uodc_pkg::IDX_IRQ_MASK) begin
            irq_mask_q <= PWDATA[uodc_pkg::IRQ_W-1:0];
         end
      end
   end

   // sticky events, set wins over write one to clear
   always_comb begin
      irq_set = '0;
      irq_set[uodc_pkg::IRQ_LOAD_BIT] = (ld_state_q == LD_APPLY);
      irq_set[uodc_pkg::IRQ_PIN_BIT]  = |chg;
      irq_stat_d = irq_stat_q;
      if (wr_fire && PADDR[9:2] == uodc_pkg::IDX_IRQ_STAT) begin
         irq_stat_d = irq_stat_q & ~PWDATA[uodc_pkg::IRQ_W-1:0];
      end
      irq_stat_d = irq_stat_d | irq_set;
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         irq_stat_q <= '0;
         irq_q      <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_q      <= |(irq_stat_d & irq_mask_q);
      end
   end

   assign PRDATA                 = prdata_q;
   assign PREADY                 = pready_q;
   assign PSLVERR                = pslverr_q;
   assign GPIO_O                 = gpio_o_q;
   assign GPIO_OE_N              = gpio_oe_n_q;
   assign PIN_CHANGE_PKT         = pkt_q;
   assign PIN_CHANGE_LEVELS      = levels_q;
   assign DESC                   = desc_q;
   assign DESC_READY             = ready_q;
   assign LATENCY_RATE_THRESHOLD = thr_q;
   assign IRQ                    = irq_q;

   // checks
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   AST_RX_TOGGLE: assert property (pincfg_q.rx_tog_sel |=> !GPIO_OE_N[9] &&
      GPIO_O[9] == $past(rx_tog_q)) else $error("pin 9 not driving receive toggle");
   AST_TX_GPIO: assert property (!pincfg_q.tx_tog_sel |=>
      GPIO_OE_N[8] == !$past(pincfg_q.dir[8])) else $error("pin 8 not general purpose");
   AST_DIR_LOW: assert property (##1 GPIO_OE_N[7:0] == ~$past(pincfg_q.dir[7:0]))
      else $error("low pin direction mismatch");
   AST_PIN_MASK: assert property (PIN_CHANGE_PKT |->
      $past(|((GPIO_I ^ gpio_in_q) & ~pincfg_q.mask))) else $error("masked change sent");
   AST_THRESHOLD: assert property (ld_state_q == LD_APPLY &&
      img_q[uodc_pkg::SLOT_OVR][uodc_pkg::OVR_THR_BIT] |=> LATENCY_RATE_THRESHOLD ==
      {$past(img_q[uodc_pkg::SLOT_THR2]), $past(img_q[uodc_pkg::SLOT_THR1]),
       $past(img_q[uodc_pkg::SLOT_THR0])}) else $error("threshold wrong");
   AST_VENDOR: assert property (ld_state_q == LD_APPLY &&
      !img_q[uodc_pkg::SLOT_PROG][uodc_pkg::PROG_VEND_BIT] |=>
      DESC.vendor == uodc_pkg::DEF_VENDOR) else $error("unprogrammed vendor code used");
   AST_WAKE: assert property (ld_state_q == LD_APPLY &&
      !img_q[uodc_pkg::SLOT_ATTR][uodc_pkg::ATTR_WAKE_VALID] |=>
      !DESC.attributes[uodc_pkg::BM_WAKE_BIT]) else $error("wake advertised without valid");
   AST_POWER: assert property (ld_state_q == LD_APPLY &&
      img_q[uodc_pkg::SLOT_PROG][uodc_pkg::PROG_ATTR_BIT] |=> DESC.attributes[7] &&
      DESC.attributes[uodc_pkg::BM_SELF_BIT] == ^$past(img_q[uodc_pkg::SLOT_ATTR][1:0]))
      else $error("power mode not reported");
   AST_LOAD: assert property ($fell(RST) |-> !DESC_READY [*8] ##1
      !DESC_READY [*8] ##1 !DESC_READY ##1 DESC_READY)
      else $error("descriptor load not finished");
   AST_NO_EARLY: assert property (busy |=> !($rose(PREADY)))
      else $error("bus answered during load");
endmodule

//--- verif/uodc_pin_env.sv
// pin-side model: external levels, wire resolution, packet count
module uodc_pin_env (
   // clock
   input  wire logic       clk,
   // design side
   input  wire logic       pkt,
   input  wire logic [9:0] oe_n,
   input  wire logic [9:0] gpo,
   output logic      [9:0] gpi,
   output int              pkt_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] ext_q = 10'h000;
   initial pkt_cnt = 0;
   // driven pins show the design value, others the outside level
   assign gpi = (~oe_n & gpo) | (oe_n & ext_q);
   always @(posedge clk) begin
      if (pkt === 1'b1)
         pkt_cnt <= pkt_cnt + 1;
   end
   task automatic set(input logic [9:0] v);
      @(posedge clk);
      ext_q <= v;
   endtask
endmodule

//--- verif/uodc_top_bench.sv
// self-checking bench of the descriptor configuration bank
module uodc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, txa = 0, rxa = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, pkt, dready, er;
   logic [9:0] gpi, gpo, oen, lvl;
   logic [23:0] thr;
   uodc_pkg::uodc_desc_t desc;
   int error_cnt = 0, num_checks = 0, c0, pcnt;
   logic [7:0] wv[16] = '{8'h1e, 8'h00, 8'h0f, 8'h01, 8'h20, 8'h00, 8'h11, 8'h22,
                          8'h33, 8'hcd, 8'hab, 8'h01, 8'hef, 8'hfa, 8'h0d, 8'h0f};
   logic [7:0] av[3] = '{8'h08, 8'h0c, 8'h06}, ev[3] = '{8'h80, 8'ha0, 8'hc0};
   always #4 clk = ~clk;
   uodc_top dut (.MCLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .GPIO_I(gpi), .GPIO_O(gpo), .GPIO_OE_N(oen), .TX_ACTIVITY(txa), .RX_ACTIVITY(rxa),
      .PIN_CHANGE_PKT(pkt), .PIN_CHANGE_LEVELS(lvl), .DESC(desc), .DESC_READY(dready),
      .LATENCY_RATE_THRESHOLD(thr), .IRQ(irq));
   uodc_pin_env env (.clk(clk), .pkt(pkt), .oe_n(oen), .gpo(gpo), .gpi(gpi), .pkt_cnt(pcnt));
   task automatic chk(input logic [47:0] s, input logic [47:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic reload;
      apb(1'b1, uodc_pkg::IDX_CTRL, 32'h1);
      @(posedge clk);
      chk(dready, 48'h0);
      apb(1'b0, uodc_pkg::IDX_STATUS, 32'h0);
      chk(rd, 48'h2);
      chk(dready, 48'h1);
      repeat (2) @(posedge clk);
   endtask
   task automatic pins(input logic [9:0] v);
      env.set(v);
      repeat (4) @(posedge clk);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      give_verdict;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, uodc_pkg::IDX_MODE_HI, 32'h0);
      chk(rd, 48'h3);
      chk(dready, 48'h1);
      chk(desc, 48'h1234_5678_32_80);
      chk(thr, 48'h0);
      chk(oen, 48'h0ff);
      txa <= 1'b1;
      rxa <= 1'b1;
      @(posedge clk);
      txa <= 1'b0;
      rxa <= 1'b0;
      repeat (3) @(posedge clk);
      chk(gpo[9:8], 48'h3);
      apb(1'b0, 8'h30, 32'h0);
      chk(er, 48'h1);
      for (int s = 0; s < 16; s++)
         apb(1'b1, uodc_pkg::IDX_OF_SLOT[s], {24'h0, wv[s]});
      for (int s = 0; s < 16; s++) begin
         apb(1'b0, uodc_pkg::IDX_OF_SLOT[s], 32'h0);
         chk(rd, wv[s]);
      end
      reload;
      chk(desc, 48'habcd_ef01_fa_e0);
      chk(thr, 48'h332211);
      chk(oen, 48'h2f0);
      apb(1'b1, uodc_pkg::IDX_IRQ_STAT, 32'h3);
      apb(1'b1, uodc_pkg::IDX_IRQ_MASK, 32'h2);
      c0 = pcnt;
      pins(10'h010);
      chk(pcnt - c0, 48'h1);
      chk(lvl, 48'h010);
      chk(irq, 48'h1);
      pins(10'h030);
      chk(pcnt - c0, 48'h1);
      apb(1'b1, uodc_pkg::IDX_GPIO_OUT, 32'h101);
      repeat (4) @(posedge clk);
      chk(gpo, 48'h101);
      chk(pcnt - c0, 48'h1);
      apb(1'b1, uodc_pkg::IDX_IRQ_STAT, 32'h2);
      repeat (2) @(posedge clk);
      chk(irq, 48'h0);
      apb(1'b1, uodc_pkg::IDX_IRQ_MASK, 32'h0);
      pins(10'h020);
      chk(pcnt - c0, 48'h2);
      chk(irq, 48'h0);
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, uodc_pkg::IDX_ATTR, {24'h0, av[k]});
         reload;
         chk(desc.attributes, ev[k]);
      end
      apb(1'b1, uodc_pkg::IDX_OVERRIDE, 32'h0);
      apb(1'b1, uodc_pkg::IDX_PROG, 32'h0);
      reload;
      chk(thr, 48'h0);
      chk(oen, 48'h0ff);
      chk(desc.vendor, 48'h1234);
      give_verdict;
   end
endmodule
